// ---- pkg/acs_pkg.sv ----
// Shared constants and types for the converter sequencing block.
// Assumes a single 40 MHz system clock and a byte-wide special function register port.
package acs_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_PAIR_CFG = 8'hBA;
    localparam logic [7:0] ADDR_CHAN_SEL = 8'hBB;
    localparam logic [7:0] ADDR_CONFIG   = 8'hBC;
    localparam logic [7:0] ADDR_RES_LO   = 8'hBE;
    localparam logic [7:0] ADDR_RES_HI   = 8'hBF;
    localparam logic [7:0] ADDR_CONTROL  = 8'hE8;

    // Reset values
    localparam logic [3:0] RST_PAIR_CFG = 4'h0;
    localparam logic [3:0] RST_CHAN_SEL = 4'h0;
    localparam logic [7:0] RST_CONFIG   = 8'hF8;

    // Control register fields
    localparam int CTL_EN_BIT   = 7;
    localparam int CTL_TM_BIT   = 6;
    localparam int CTL_DONE_BIT = 5;
    localparam int CTL_BUSY_BIT = 4;
    localparam int CTL_SRC_HI   = 3;
    localparam int CTL_SRC_LO   = 2;
    localparam int CTL_WINT_BIT = 1;
    localparam int CTL_LJST_BIT = 0;

    // Configuration register fields
    localparam int CFG_SC_HI   = 7;
    localparam int CFG_SC_LO   = 3;
    localparam int CFG_GAIN_HI = 2;

    // Timing
    localparam int SYS_CLK_HZ       = 40_000_000;
    localparam int MAX_RATE_SPS     = 100_000;
    localparam int CONV_MIN_CYCLES  = (SYS_CLK_HZ + MAX_RATE_SPS - 1) / MAX_RATE_SPS;
    localparam logic [8:0] RATE_RELOAD = 9'(CONV_MIN_CYCLES - 1);
    localparam int TRACK_SAR_CLOCKS = 3;
    localparam logic [1:0] TRACK_LAST = 2'(TRACK_SAR_CLOCKS - 1);
    localparam int RESULT_BITS      = 12;
    localparam logic [3:0] SAR_TOP_BIT = 4'(RESULT_BITS - 1);
    localparam logic [11:0] SAR_FIRST_TRIAL = 12'h800;

    typedef enum logic [1:0] {
        SRC_BUSY_WRITE = 2'b00,
        SRC_TIMER3     = 2'b01,
        SRC_EXT        = 2'b10,
        SRC_TIMER2     = 2'b11
    } acs_src_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_TRACK = 4'b0010,
        ST_CONV  = 4'b0100,
        ST_HOLD  = 4'b1000
    } acs_state_t;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } acs_sfr_req_t;

    typedef struct packed {
        logic timer3_ovf;
        logic timer2_ovf;
        logic ext_convert_start;
        logic chip_standby;
    } acs_trig_t;

    typedef struct packed {
        logic        shutdown;
        logic        track;
        logic        convert;
        logic        sar_tick;
        logic [11:0] trial;
        logic [2:0]  pos_sel;
        logic [2:0]  neg_sel;
        logic        diff;
        logic        temp_sel;
        logic [2:0]  gain;
    } acs_analog_t;

    typedef struct packed {
        logic [3:0]  pair_cfg;
        logic [3:0]  chan_sel;
        logic [7:0]  cfg;
        logic        en;
        logic        tm;
        logic        done;
        acs_src_t    src;
        logic        wint;
        logic        ljst;
        acs_state_t  state;
        logic [5:0]  div_cnt;
        logic [1:0]  trk_cnt;
        logic [3:0]  bit_idx;
        logic [11:0] trial;
        logic [11:0] result;
        logic        res_diff;
        logic        conv_diff;
        logic [8:0]  rate_cnt;
        logic        ext_prev;
        logic [7:0]  rdata;
    } acs_regs_t;

endpackage : acs_pkg

// ---- core/acs_sequencer.sv ----
// Conversion sequencer: start sources, busy/done, tracking, SAR stepping, result format, mux.
// Assumes all inputs synchronous to core_clk_in; comparator result valid at each SAR tick.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// R1 - Busy write starts conversion in software mode
// R2 - Timer 3 overflow starts conversion
// R3 - External input rising edge starts conversion
// R4 - Timer 2 overflow starts conversion
// R5 - Busy high for whole conversion
// R6 - Busy falling sets done flag, interrupt
// R7 - Result justified left or right by select
// R8 - Software clears flag, starts, polls, reads
// R9 - Default mode tracks whenever not converting
// R10 - Low-power mode tracks three SAR clocks first
// R11 - External low-power: track low, convert rising
// R12 - SAR clock divided per config field
// R13 - At most 100 ksps conversion rate
// R14 - Chip standby stops tracking
// R15 - Software waits 1.5 us after mux change
// R16 - Software routes external pin as open-drain
// R17 - Pair bits choose single-ended or differential
// R18 - Differential results in two's complement
// R19 - Codes 0-7 inputs, 1xxx temperature sensor
// R20 - Mux upper nibbles read zero, ignore writes
// R21 - Pair configuration resets to zero
// R22 - Enable bit low keeps converter shut down
// R23 - Two-bit field selects start source
// R24 - Done flag cleared only by software
// R25 - Busy write starts only for source 00
// R26 - Either code of differential pair routes pair
// R27 - Starts while busy are ignored
module acs_sequencer (
    // Clock and reset
    input  wire logic                 core_clk_in,
    input  wire logic                 rst_n_in,
    // Register port
    input  wire acs_pkg::acs_sfr_req_t sfr_req_in,
    output logic [7:0]                sfr_rdata_out,
    // Triggers and chip state
    input  wire acs_pkg::acs_trig_t   trig_in,
    input  wire logic                 irq_enable_in,
    output logic                      irq_out,
    // Analog front end
    input  wire logic                 comparator_in,
    output acs_pkg::acs_analog_t      analog_out
);

    acs_pkg::acs_regs_t r_q;
    acs_pkg::acs_regs_t r_d;

    function automatic logic [15:0] justify(input logic [11:0] res, input logic diff,
                                            input logic left);
        if (left) begin
            justify = {res, 4'h0};
        end else begin
            justify = {(diff ? {4{res[11]}} : 4'h0), res};
        end
    endfunction : justify

    logic        wr_ctl;
    logic        busy;
    logic        sar_tick;
    logic [5:0]  div_top;
    logic        ext_rise;
    logic        start_evt;
    logic        done_evt;
    logic        pair_diff;
    logic [15:0] res_word;
    logic [11:0] trial_upd;

    always_comb begin
        r_d       = r_q;
        wr_ctl    = sfr_req_in.wr && (sfr_req_in.addr == acs_pkg::ADDR_CONTROL);
        busy      = (r_q.state != acs_pkg::ST_IDLE);
        div_top   = (r_q.cfg[acs_pkg::CFG_SC_HI:acs_pkg::CFG_SC_LO] == 5'h00) ? 6'h00 :
                    {r_q.cfg[acs_pkg::CFG_SC_HI:acs_pkg::CFG_SC_LO], 1'b1}; // R12
        sar_tick  = r_q.en && (r_q.div_cnt == div_top); // R12
        ext_rise  = trig_in.ext_convert_start && !r_q.ext_prev;
        done_evt  = 1'b0;
        trial_upd = r_q.trial;
        pair_diff = r_q.pair_cfg[r_q.chan_sel[2:1]] && !r_q.chan_sel[3]; // R17
        res_word  = justify(r_q.result, r_q.res_diff, r_q.ljst); // R7

        // Start source selection
        case (r_q.src) // R23
            acs_pkg::SRC_BUSY_WRITE: start_evt = wr_ctl &&
                                     sfr_req_in.wdata[acs_pkg::CTL_BUSY_BIT]; // R1 R25
            acs_pkg::SRC_TIMER3:     start_evt = trig_in.timer3_ovf; // R2
            acs_pkg::SRC_EXT:        start_evt = ext_rise; // R3 R11
            acs_pkg::SRC_TIMER2:     start_evt = trig_in.timer2_ovf; // R4
            default:                 start_evt = 1'b0;
        endcase
        start_evt = start_evt && r_q.en && !busy; // R22 R27

        // SAR clock divider
        r_d.div_cnt = (!r_q.en || sar_tick) ? 6'h00 : 6'(r_q.div_cnt + 6'h01);
        r_d.ext_prev = trig_in.ext_convert_start;
        if (r_q.rate_cnt != 9'h000) begin
            r_d.rate_cnt = 9'(r_q.rate_cnt - 9'h001);
        end

        // Conversion sequence
        case (r_q.state)
            acs_pkg::ST_IDLE: begin
                if (start_evt) begin
                    r_d.rate_cnt  = acs_pkg::RATE_RELOAD; // R13
                    r_d.conv_diff = pair_diff; // R18
                    r_d.trk_cnt   = 2'h0;
                    r_d.trial     = acs_pkg::SAR_FIRST_TRIAL;
                    r_d.bit_idx   = acs_pkg::SAR_TOP_BIT;
                    if (r_q.tm && (r_q.src != acs_pkg::SRC_EXT)) begin
                        r_d.state = acs_pkg::ST_TRACK; // R10
                    end else begin
                        r_d.state = acs_pkg::ST_CONV; // R11
                    end
                end
            end
            acs_pkg::ST_TRACK: begin
                if (sar_tick) begin
                    r_d.trk_cnt = 2'(r_q.trk_cnt + 2'h1);
                    if (r_q.trk_cnt == acs_pkg::TRACK_LAST) begin
                        r_d.state = acs_pkg::ST_CONV; // R10
                    end
                end
            end
            acs_pkg::ST_CONV: begin
                if (sar_tick) begin
                    if (!comparator_in) begin
                        trial_upd[r_q.bit_idx] = 1'b0;
                    end
                    if (r_q.bit_idx == 4'h0) begin
                        r_d.result   = r_q.conv_diff ? {~trial_upd[11], trial_upd[10:0]} :
                                       trial_upd; // R18
                        r_d.res_diff = r_q.conv_diff;
                        r_d.state    = acs_pkg::ST_HOLD;
                    end else begin
                        trial_upd[4'(r_q.bit_idx - 4'h1)] = 1'b1;
                        r_d.bit_idx = 4'(r_q.bit_idx - 4'h1);
                    end
                    r_d.trial = trial_upd;
                end
            end
            acs_pkg::ST_HOLD: begin
                if (r_q.rate_cnt == 9'h000) begin
                    r_d.state = acs_pkg::ST_IDLE; // R5 R13
                    done_evt  = 1'b1; // R6
                end
            end
            default: r_d.state = acs_pkg::ST_IDLE;
        endcase

        // Register writes
        if (sfr_req_in.wr) begin
            case (sfr_req_in.addr)
                acs_pkg::ADDR_PAIR_CFG: r_d.pair_cfg = sfr_req_in.wdata[3:0]; // R20
                acs_pkg::ADDR_CHAN_SEL: r_d.chan_sel = sfr_req_in.wdata[3:0]; // R20
                acs_pkg::ADDR_CONFIG:   r_d.cfg      = sfr_req_in.wdata;
                acs_pkg::ADDR_CONTROL: begin
                    r_d.en   = sfr_req_in.wdata[acs_pkg::CTL_EN_BIT];
                    r_d.tm   = sfr_req_in.wdata[acs_pkg::CTL_TM_BIT];
                    r_d.done = sfr_req_in.wdata[acs_pkg::CTL_DONE_BIT];
                    r_d.src  = acs_pkg::acs_src_t'(
                               sfr_req_in.wdata[acs_pkg::CTL_SRC_HI:acs_pkg::CTL_SRC_LO]);
                    r_d.wint = sfr_req_in.wdata[acs_pkg::CTL_WINT_BIT];
                    r_d.ljst = sfr_req_in.wdata[acs_pkg::CTL_LJST_BIT];
                end
                default: r_d.rdata = r_d.rdata;
            endcase
        end
        if (done_evt) begin
            r_d.done = 1'b1; // R6 R24
        end
        // Clearing enable stops the sequence in the same edge
        if (!r_d.en) begin
            r_d.state = acs_pkg::ST_IDLE; // R22
        end

        // Registered read data
        case (sfr_req_in.addr)
            acs_pkg::ADDR_PAIR_CFG: r_d.rdata = {4'h0, r_q.pair_cfg}; // R20
            acs_pkg::ADDR_CHAN_SEL: r_d.rdata = {4'h0, r_q.chan_sel}; // R20
            acs_pkg::ADDR_CONFIG:   r_d.rdata = r_q.cfg;
            acs_pkg::ADDR_RES_HI:   r_d.rdata = res_word[15:8]; // R7
            acs_pkg::ADDR_RES_LO:   r_d.rdata = res_word[7:0]; // R7
            acs_pkg::ADDR_CONTROL:  r_d.rdata = {r_q.en, r_q.tm, r_q.done, busy, r_q.src,
                                                 r_q.wint, r_q.ljst}; // R5
            default:                r_d.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r_q          <= '0;
            r_q.pair_cfg <= acs_pkg::RST_PAIR_CFG; // R21
            r_q.chan_sel <= acs_pkg::RST_CHAN_SEL;
            r_q.cfg      <= acs_pkg::RST_CONFIG;
            r_q.src      <= acs_pkg::SRC_BUSY_WRITE;
            r_q.state    <= acs_pkg::ST_IDLE;
        end else begin
            r_q <= r_d;
        end
    end

    // Outputs
    always_comb begin
        sfr_rdata_out       = r_q.rdata;
        irq_out             = r_q.done && irq_enable_in; // R6
        analog_out.shutdown = !r_q.en; // R22
        analog_out.convert  = (r_q.state == acs_pkg::ST_CONV);
        analog_out.sar_tick = r_q.en && (r_q.div_cnt == div_top);
        analog_out.trial    = r_q.trial;
        analog_out.gain     = r_q.cfg[acs_pkg::CFG_GAIN_HI:0];
        analog_out.temp_sel = r_q.chan_sel[3]; // R19
        analog_out.diff     = pair_diff; // R17
        analog_out.pos_sel  = pair_diff ? {r_q.chan_sel[2:1], 1'b0} : r_q.chan_sel[2:0]; // R26
        analog_out.neg_sel  = pair_diff ? {r_q.chan_sel[2:1], 1'b1} : 3'h0; // R26
        if (!r_q.en || trig_in.chip_standby) begin
            analog_out.track = 1'b0; // R14 R22
        end else if (r_q.state == acs_pkg::ST_TRACK) begin
            analog_out.track = 1'b1; // R10
        end else if (r_q.state != acs_pkg::ST_IDLE) begin
            analog_out.track = 1'b0;
        end else if (!r_q.tm) begin
            analog_out.track = 1'b1; // R9
        end else begin
            analog_out.track = (r_q.src == acs_pkg::SRC_EXT) && !trig_in.ext_convert_start; // R11
        end
    end

endmodule : acs_sequencer
`default_nettype wire

// ---- tb/acs_props.sv ----
// Port checker for the conversion sequencer.
// Assumes it is bound onto acs_sequencer and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module acs_props (
    // Clock and reset
    input wire logic                  core_clk_in,
    input wire logic                  rst_n_in,
    // Register port
    input wire acs_pkg::acs_sfr_req_t sfr_req_in,
    input wire logic [7:0]            sfr_rdata_out,
    // Triggers and chip state
    input wire acs_pkg::acs_trig_t    trig_in,
    input wire logic                  irq_enable_in,
    input wire logic                  irq_out,
    // Analog front end
    input wire logic                  comparator_in,
    input wire acs_pkg::acs_analog_t  analog_out
);
    logic [8:0] gap_q;
    logic [8:0] gap_d;
    logic       wr_ctl;
    assign wr_ctl = sfr_req_in.wr && sfr_req_in.addr == acs_pkg::ADDR_CONTROL;
    always_comb begin
        gap_d = (gap_q == 9'h1FF) ? gap_q : gap_q + 9'h001;
    end
    // Cycles since the last conversion began
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) gap_q <= 9'h1FF;
        else if ($rose(analog_out.convert)) gap_q <= 9'h000;
        else gap_q <= gap_d;
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    conv_no_track_a: assert property (analog_out.convert |-> !analog_out.track)
        else $error("tracking during conversion");
    conv_rate_a: assert property ($rose(analog_out.convert) |-> gap_q >= 9'h18F)
        else $error("conversions closer than 400 cycles");
    off_quiet_a: assert property (analog_out.shutdown
        |-> !analog_out.convert && !analog_out.track)
        else $error("activity while shut down");
    enable_follow_a: assert property (wr_ctl
        |=> analog_out.shutdown == !$past(sfr_req_in.wdata[7]))
        else $error("shutdown does not follow enable bit");
    standby_track_a: assert property (trig_in.chip_standby |-> !analog_out.track)
        else $error("tracking in standby");
    temp_code_a: assert property (sfr_req_in.wr && sfr_req_in.addr == acs_pkg::ADDR_CHAN_SEL
        |=> analog_out.temp_sel == $past(sfr_req_in.wdata[3]))
        else $error("temperature select wrong");
    gain_load_a: assert property (sfr_req_in.wr && sfr_req_in.addr == acs_pkg::ADDR_CONFIG
        |=> analog_out.gain == $past(sfr_req_in.wdata[2:0]))
        else $error("gain field not loaded");
    done_hold_a: assert property (irq_out && irq_enable_in && !wr_ctl
        |=> irq_out || !irq_enable_in)
        else $error("done flag cleared by hardware");
    pair_route_a: assert property (analog_out.diff && !analog_out.temp_sel
        |-> !analog_out.pos_sel[0] && analog_out.neg_sel == (analog_out.pos_sel | 3'h1))
        else $error("differential pair routed wrongly");
    cover property ($fell(analog_out.convert));
    cover property ($rose(irq_out));
    cover property (analog_out.track && !trig_in.ext_convert_start);
endmodule : acs_props
bind acs_sequencer acs_props u_props (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .sfr_req_in(sfr_req_in), .sfr_rdata_out(sfr_rdata_out), .trig_in(trig_in),
    .irq_enable_in(irq_enable_in), .irq_out(irq_out), .comparator_in(comparator_in),
    .analog_out(analog_out));
`default_nettype wire

// ---- tb/acs_analog_model.sv ----
// Comparator model of the analog front end.
// Assumes level_in is the offset code of the sampled input.
`timescale 1ns/100ps
`default_nettype none
module acs_analog_model (
    // Clock
    input wire logic                 core_clk_in,
    // Converter side
    input wire acs_pkg::acs_analog_t analog_in,
    input wire logic [11:0]          level_in,
    output logic                     comparator_out
);
    logic wander_q = 1'b0;
    always_ff @(posedge core_clk_in) wander_q <= ~wander_q;
    // Answers at once in conversion; meaningless level otherwise
    assign comparator_out = analog_in.convert ? (level_in >= analog_in.trial) : wander_q;
endmodule : acs_analog_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the conversion sequencer.
// Assumes the comparator model as far side and a 40 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic                  clk;
    logic                  rst_n;
    acs_pkg::acs_sfr_req_t req;
    acs_pkg::acs_trig_t    trig;
    acs_pkg::acs_analog_t  ana;
    logic [7:0]            rdata;
    logic                  irq;
    logic                  irq_en;
    logic                  cmp;
    logic [11:0]           level;
    int                    mismatches;
    int                    n_tests;
    int                    ticks;
    acs_sequencer uut (.core_clk_in(clk), .rst_n_in(rst_n), .sfr_req_in(req),
        .sfr_rdata_out(rdata), .trig_in(trig), .irq_enable_in(irq_en), .irq_out(irq),
        .comparator_in(cmp), .analog_out(ana));
    acs_analog_model far (.core_clk_in(clk), .analog_in(ana), .level_in(level),
        .comparator_out(cmp));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic test_done;
        if (mismatches == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1 req = '{wr: 1'b1, addr: a, wdata: d};
        @(posedge clk) #1 req.wr = 1'b0;
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk) #1 req.addr = a;
        repeat (2) @(posedge clk);
        #1 chk({8'h00, rdata}, {8'h00, e});
    endtask : rdchk
    task automatic pulse(input logic [1:0] src);
        @(posedge clk) #1 trig.ext_convert_start = 1'b0;
        trig.timer3_ovf = (src == 2'h1);
        trig.timer2_ovf = (src == 2'h3);
        @(posedge clk) #1 trig.ext_convert_start = 1'b1;
        trig.timer3_ovf = 1'b0;
        trig.timer2_ovf = 1'b0;
    endtask : pulse
    task automatic start(input logic [1:0] src, input logic [7:0] ctl);
        if (src == 2'h0) wr(acs_pkg::ADDR_CONTROL, ctl | 8'h10);
        else pulse(src);
    endtask : start
    function automatic logic [15:0] exp_word(input logic [11:0] v, input logic d, input logic l);
        logic [11:0] r;
        r = d ? v ^ 12'h800 : v;
        return l ? {r, 4'h0} : {{4{d & r[11]}}, r};
    endfunction : exp_word
    task automatic conv(input logic [1:0] src, input logic tm, input logic lj,
                        input logic [3:0] pair, input logic [3:0] chan, input logic [11:0] v);
        logic       diff;
        logic [7:0] ctl;
        logic [15:0] e;
        int         n;
        diff = !chan[3] && pair[chan[2:1]];
        ctl = {1'b1, tm, 2'b00, src, 1'b0, lj};
        level = v;
        trig.ext_convert_start = 1'b0;
        wr(acs_pkg::ADDR_CONFIG, 8'h00);
        wr(acs_pkg::ADDR_PAIR_CFG, {4'h0, pair});
        wr(acs_pkg::ADDR_CHAN_SEL, {4'h0, chan});
        wr(acs_pkg::ADDR_CONTROL, ctl);
        repeat (60) @(posedge clk);
        #1;
        if (!chan[3]) chk(16'(ana.pos_sel), 16'(diff ? {chan[2:1], 1'b0} : chan[2:0]));
        if (diff) chk(16'(ana.neg_sel), 16'({chan[2:1], 1'b1}));
        if (!tm || src == 2'h2) chk(16'(ana.track), 16'h1);
        start(src, ctl);
        if (src == 2'h0) chk(16'({ana.track, ana.convert}), tm ? 16'h2 : 16'h1);
        start(src, ctl);
        rdchk(acs_pkg::ADDR_CONTROL, ctl | 8'h10);
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge clk) #1;
            n++;
        end
        chk(16'(irq), 16'h1);
        chk(16'(n), 16'(acs_pkg::CONV_MIN_CYCLES - ((src == 2'h2) ? 4 : 5)));
        e = exp_word(v, diff, lj);
        rdchk(acs_pkg::ADDR_CONTROL, ctl | 8'h20);
        rdchk(acs_pkg::ADDR_RES_HI, e[15:8]);
        rdchk(acs_pkg::ADDR_RES_LO, e[7:0]);
    endtask : conv
    initial begin
        rst_n = 1'b0;
        req = '0;
        trig = '0;
        irq_en = 1'b1;
        level = 12'h000;
        mismatches = 0;
        n_tests = 0;
        void'($urandom(97));
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        rdchk(acs_pkg::ADDR_CONTROL, 8'h00);
        rdchk(acs_pkg::ADDR_CONFIG, 8'hF8);
        rdchk(acs_pkg::ADDR_PAIR_CFG, 8'h00);
        rdchk(acs_pkg::ADDR_CHAN_SEL, 8'h00);
        rdchk(8'h01, 8'h00);
        wr(acs_pkg::ADDR_PAIR_CFG, 8'hFF);
        rdchk(acs_pkg::ADDR_PAIR_CFG, 8'h0F);
        wr(acs_pkg::ADDR_CHAN_SEL, 8'hA9);
        rdchk(acs_pkg::ADDR_CHAN_SEL, 8'h09);
        wr(acs_pkg::ADDR_CONTROL, 8'h84);
        wr(acs_pkg::ADDR_CONTROL, 8'h94);
        repeat (500) @(posedge clk);
        chk(16'(irq), 16'h0);
        rdchk(acs_pkg::ADDR_CONTROL, 8'h84);
        conv(2'h0, 1'b0, 1'b0, 4'hF, 4'h1, 12'h000);
        conv(2'h2, 1'b1, 1'b1, 4'h0, 4'h8, 12'hFFF);
        for (int i = 0; i < 8; i++) begin
            conv(2'(i), 1'(i >> 2), 1'(i), 4'h3, 4'(i), 12'($urandom));
        end
        repeat (8) conv(2'($urandom), 1'($urandom), 1'($urandom), 4'($urandom),
                        4'($urandom), 12'($urandom));
        wr(acs_pkg::ADDR_CONFIG, 8'h08);
        ticks = 0;
        repeat (40) @(posedge clk) #1 ticks += int'(ana.sar_tick);
        chk(16'(ticks), 16'h000A);
        @(posedge clk) #1 trig.chip_standby = 1'b1;
        irq_en = 1'b0;
        @(posedge clk) #1 chk(16'(ana.track), 16'h0);
        chk(16'(irq), 16'h0);
        wr(acs_pkg::ADDR_CONTROL, 8'h00);
        chk(16'(ana.shutdown), 16'h1);
        test_done();
    end
    initial begin
        #1500000;
        mismatches++;
        test_done();
    end
endmodule : testbench
`default_nettype wire
